// [hw/eep_pkg.sv]
// shared constants and types for the serial eeprom command and protect logic
package eep_pkg;

    // array geometry (larger density)
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 15;
    localparam int PAGE_W = 6;
    localparam int PAGE_BYTES = 64;
    localparam int MEM_DEPTH = 32768;
    localparam int SYNC_STAGES = 3;

    // timing
    localparam int CLK_FREQ_KHZ = 250000;
    localparam int WRITE_CYCLE_TIME_MS = 5;
    localparam int WRITE_CYCLE_CYCLES = WRITE_CYCLE_TIME_MS * CLK_FREQ_KHZ;
    localparam int TIMER_W = 21;

    // opcodes, bit 3 is ignored on decode
    localparam logic [7:0] OPC_MASK = 8'hf7;
    localparam logic [7:0] OPC_LATCH_SET = 8'h06;
    localparam logic [7:0] OPC_LATCH_CLEAR = 8'h04;
    localparam logic [7:0] OPC_STATUS_READ = 8'h05;
    localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OPC_ARRAY_READ = 8'h03;
    localparam logic [7:0] OPC_ARRAY_WRITE = 8'h02;

    // status register layout
    localparam int ST_PROTECT_PIN_ENABLE_BIT = 7;
    localparam int ST_RFU_HI = 6;
    localparam int ST_RFU_LO = 4;
    localparam int ST_BP_HI = 3;
    localparam int ST_BP_LO = 2;
    localparam int ST_WEL_BIT = 1;
    localparam int ST_BUSY_BIT = 0;

    // power-up values of the nonvolatile status bits
    localparam logic NV_PROTECT_PIN_ENABLE_INIT = 1'b0;
    localparam logic [1:0] NV_BP_INIT = 2'b00;

    // block protect levels
    localparam logic [1:0] BP_NONE = 2'b00;
    localparam logic [1:0] BP_QUARTER = 2'b01;
    localparam logic [1:0] BP_HALF = 2'b10;
    localparam logic [1:0] BP_ALL = 2'b11;
    localparam logic [ADDR_W-1:0] QUARTER_BASE = 15'h6000;
    localparam logic [ADDR_W-1:0] HALF_BASE = 15'h4000;

    localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
    localparam logic [2:0] OUT_FIRST_BIT = 3'h7;
    localparam logic [2:0] OUT_LAST_BIT = 3'h0;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b000,
        SEQ_CMD = 3'b001,
        SEQ_ADDR = 3'b011,
        SEQ_XFER = 3'b010,
        SEQ_SKIP = 3'b110
    } eep_seq_t;

    typedef enum logic [2:0] {
        CMD_NONE = 3'h0,
        CMD_LATCH_SET = 3'h1,
        CMD_LATCH_CLEAR = 3'h2,
        CMD_STATUS_READ = 3'h3,
        CMD_STATUS_WRITE = 3'h4,
        CMD_ARRAY_READ = 3'h5,
        CMD_ARRAY_WRITE = 3'h6
    } eep_cmd_t;

endpackage : eep_pkg

// [hw/eep_mem_if.sv]
// link between the command logic and the byte array memory
interface eep_mem_if;
    logic wr_en;
    logic [eep_pkg::ADDR_W-1:0] wr_addr;
    logic [eep_pkg::BYTE_W-1:0] wr_data;
    logic [eep_pkg::ADDR_W-1:0] rd_addr;
    logic [eep_pkg::BYTE_W-1:0] rd_data;

    modport ctrl (output wr_en, output wr_addr, output wr_data,
                  output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data,
                 input rd_addr, output rd_data);
endinterface : eep_mem_if

// [hw/eep_array_mem.sv]
// byte array with one write port and a registered read port
module eep_array_mem (
    input wire logic clock_in,
    input wire logic rstn_in,
    eep_mem_if.mem mem_if
);
    import eep_pkg::*;

    logic [BYTE_W-1:0] cells [0:MEM_DEPTH-1];
    logic [BYTE_W-1:0] rd_data_reg;

    // the cell array carries no reset: its content is the stored data
    always_ff @(posedge clock_in) begin
        if (mem_if.wr_en) begin
            cells[mem_if.wr_addr] <= mem_if.wr_data;
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rd_data_reg <= '0;
        end else begin
            rd_data_reg <= cells[mem_if.rd_addr];
        end
    end

    assign mem_if.rd_data = rd_data_reg;

endmodule : eep_array_mem

// [hw/eep_spi_protect.sv]
// spi slave command decode, write protection and self-timed write cycle
//
// Operation
// - status write needs the write enable latch set, else it is ignored
// - status write changes only bits 7, 3 and 2
// - protect pin enable and block protect bits are kept as nonvolatile; here reset reloads them with NV_PROTECT_PIN_ENABLE_INIT and NV_BP_INIT
// - during a write cycle only status read is accepted
// - end of a status write cycle clears the write enable latch
// - write cycle starts on chip select rise after a valid sequence
// - protect level 01 makes the upper quarter read only
// - protect level 10 makes the upper half read only
// - protect level 11 makes the whole array read only
// - pin enable clear: array by protect bits, status by latch only
// - pin low with enable set blocks status writes and protected blocks
// - pin high or enable clear: status writes need only the latch
// - protect pin enable cannot be cleared while the pin is low
// - 15 address bits decoded, the top address bit is ignored
// - after the address, input is ignored and data shifts out msb first
// - read address increments and wraps from top to zero
// - write with latch clear is ignored until chip select rises
// - bytes inside the protected range are never programmed
// - end of an array write cycle clears the write enable latch
// - page write increments only the six lowest address bits
// - bytes past the row end wrap to the row start and overwrite
// - status bit 0 reads one while a write cycle runs
// - opcode 06h sets the latch at chip select rise; powers up clear
// - opcode 05h returns the 8-bit status on serial output
// - msb first; each command starts at chip select fall
// - opcode 04h clears the latch regardless of the protect pin
module eep_spi_protect #(
    parameter int unsigned WC_CYCLES = eep_pkg::WRITE_CYCLE_CYCLES
) (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_sck_in,
    input wire logic spi_si_in,
    input wire logic wp_n_in,
    output logic spi_so_out,
    output logic spi_so_oe_out
);
    import eep_pkg::*;

    typedef struct packed {
        logic [SYNC_STAGES-1:0] cs_sync;
        logic [SYNC_STAGES-1:0] sck_sync;
        logic [SYNC_STAGES-1:0] si_sync;
        logic [SYNC_STAGES-1:0] wp_sync;
        logic cs_n;
        logic sck;
        logic si;
        logic wp_n;
        eep_seq_t seq;
        eep_cmd_t cmd;
        logic [2:0] bit_cnt;
        logic [BYTE_W-1:0] shift;
        logic addr_hi;
        logic [ADDR_W-1:0] addr;
        logic [2:0] out_idx;
        logic complete;
        logic write_enable_latch;
        logic protect_pin_enable;
        logic [1:0] bp;
        logic [BYTE_W-1:0] wrsr_data;
        logic busy;
        logic wc_status;
        logic [TIMER_W-1:0] timer;
        logic [PAGE_W:0] commit_idx;
        logic [PAGE_BYTES-1:0] page_mask;
        logic [PAGE_BYTES-1:0][BYTE_W-1:0] page_data;
        logic so;
        logic so_oe;
    } eep_state_t;

    eep_state_t state_reg;
    eep_state_t state_next;

    eep_mem_if mem_if ();

    eep_array_mem u_array (
        .clock_in(clock_in),
        .rstn_in(rstn_in),
        .mem_if(mem_if.mem)
    );

    // constant power-up image of the whole state
    function automatic eep_state_t reset_state();
        eep_state_t s;
        s = '0;
        s.cs_sync = '1;
        s.wp_sync = '1;
        s.cs_n = 1'b1;
        s.wp_n = 1'b1;
        s.seq = SEQ_IDLE;
        s.cmd = CMD_NONE;
        s.write_enable_latch = 1'b0;
        s.protect_pin_enable = NV_PROTECT_PIN_ENABLE_INIT;
        s.bp = NV_BP_INIT;
        return s;
    endfunction : reset_state

    // a pin level is taken once the second and third stage agree
    function automatic logic sync_filter(
        input logic [SYNC_STAGES-1:0] sync,
        input logic prev
    );
        return (sync[1] == sync[2]) ? sync[2] : prev;
    endfunction : sync_filter

    function automatic eep_cmd_t decode_cmd(input logic [BYTE_W-1:0] op);
        eep_cmd_t c;
        c = CMD_NONE;
        case (op & OPC_MASK)
            OPC_LATCH_SET: c = CMD_LATCH_SET;
            OPC_LATCH_CLEAR: c = CMD_LATCH_CLEAR;
            OPC_STATUS_READ: c = CMD_STATUS_READ;
            OPC_STATUS_WRITE: c = CMD_STATUS_WRITE;
            OPC_ARRAY_READ: c = CMD_ARRAY_READ;
            OPC_ARRAY_WRITE: c = CMD_ARRAY_WRITE;
            default: c = CMD_NONE;
        endcase
        return c;
    endfunction : decode_cmd

    function automatic logic is_protected(
        input logic [1:0] bp,
        input logic [ADDR_W-1:0] addr
    );
        logic p;
        p = 1'b0;
        case (bp)
            BP_NONE: p = 1'b0;
            BP_QUARTER: p = (addr >= QUARTER_BASE);
            BP_HALF: p = (addr >= HALF_BASE);
            BP_ALL: p = 1'b1;
            default: p = 1'b1;
        endcase
        return p;
    endfunction : is_protected

    function automatic logic [BYTE_W-1:0] status_value(
        input eep_state_t s
    );
        logic [BYTE_W-1:0] v;
        v[ST_PROTECT_PIN_ENABLE_BIT] = s.protect_pin_enable;
        v[ST_RFU_HI:ST_RFU_LO] = {3{s.busy}};
        v[ST_BP_HI:ST_BP_LO] = s.bp;
        v[ST_WEL_BIT] = s.write_enable_latch;
        v[ST_BUSY_BIT] = s.busy;
        return v;
    endfunction : status_value

    always_comb begin
        logic [BYTE_W-1:0] byte_v;
        logic byte_end;
        logic cs_rise;
        logic cs_fall;
        logic sck_rise;
        logic sck_fall;
        logic hw_protect;
        logic reading;
        logic [PAGE_W-1:0] col;
        eep_cmd_t cmd_v;
        logic [BYTE_W-1:0] stat_v;
        byte_v = '0;
        byte_end = 1'b0;
        cs_rise = 1'b0;
        cs_fall = 1'b0;
        sck_rise = 1'b0;
        sck_fall = 1'b0;
        hw_protect = 1'b0;
        reading = 1'b0;
        col = '0;
        cmd_v = CMD_NONE;
        stat_v = status_value(state_reg);
        state_next = state_reg;

        // pin synchronisers
        state_next.cs_sync = {state_reg.cs_sync[1:0], spi_cs_n_in};
        state_next.sck_sync = {state_reg.sck_sync[1:0], spi_sck_in};
        state_next.si_sync = {state_reg.si_sync[1:0], spi_si_in};
        state_next.wp_sync = {state_reg.wp_sync[1:0], wp_n_in};
        state_next.cs_n = sync_filter(state_reg.cs_sync, state_reg.cs_n);
        state_next.sck = sync_filter(state_reg.sck_sync, state_reg.sck);
        state_next.si = sync_filter(state_reg.si_sync, state_reg.si);
        state_next.wp_n = sync_filter(state_reg.wp_sync, state_reg.wp_n);

        cs_fall = state_reg.cs_n & ~state_next.cs_n;
        cs_rise = ~state_reg.cs_n & state_next.cs_n;
        sck_rise = ~state_reg.sck & state_next.sck & ~state_reg.cs_n;
        sck_fall = state_reg.sck & ~state_next.sck & ~state_reg.cs_n;
        byte_v = {state_reg.shift[BYTE_W-2:0], state_next.si};
        byte_end = sck_rise && (state_reg.bit_cnt == BYTE_LAST_BIT);
        hw_protect = state_reg.protect_pin_enable & ~state_reg.wp_n;
        reading = (state_reg.cmd == CMD_STATUS_READ) ||
                  (state_reg.cmd == CMD_ARRAY_READ);

        // self-timed write cycle
        if (state_reg.busy) begin
            if (!state_reg.commit_idx[PAGE_W]) begin
                state_next.commit_idx = state_reg.commit_idx + 1'b1;
            end
            if (state_reg.timer == TIMER_W'(WC_CYCLES - 1)) begin
                state_next.busy = 1'b0;
                state_next.write_enable_latch = 1'b0;
                if (state_reg.wc_status) begin
                    // only the protect enable and level bits take the byte
                    state_next.protect_pin_enable = state_reg.wrsr_data[ST_PROTECT_PIN_ENABLE_BIT];
                    state_next.bp =
                        state_reg.wrsr_data[ST_BP_HI:ST_BP_LO];
                end
            end else begin
                state_next.timer = state_reg.timer + 1'b1;
            end
        end

        if (cs_fall) begin
            state_next.seq = SEQ_CMD;
            state_next.cmd = CMD_NONE;
            state_next.bit_cnt = '0;
            state_next.complete = 1'b0;
            state_next.addr_hi = 1'b0;
            state_next.so_oe = 1'b0;
        end else if (cs_rise) begin
            state_next.seq = SEQ_IDLE;
            state_next.so_oe = 1'b0;
            state_next.so = 1'b0;
            if (state_reg.complete && !state_reg.busy) begin
                case (state_reg.cmd)
                    CMD_LATCH_SET: begin
                        state_next.write_enable_latch = 1'b1;
                    end
                    CMD_LATCH_CLEAR: begin
                        state_next.write_enable_latch = 1'b0;
                    end
                    CMD_STATUS_WRITE: begin
                        // hardware protection locks the whole status byte
                        if (state_reg.write_enable_latch && !hw_protect) begin
                            state_next.busy = 1'b1;
                            state_next.wc_status = 1'b1;
                            state_next.timer = '0;
                            state_next.commit_idx = '0;
                        end
                    end
                    CMD_ARRAY_WRITE: begin
                        state_next.busy = 1'b1;
                        state_next.wc_status = 1'b0;
                        state_next.timer = '0;
                        state_next.commit_idx = '0;
                    end
                    default: begin
                    end
                endcase
            end
        end else if (state_reg.seq != SEQ_IDLE) begin
            if (sck_rise) begin
                state_next.shift = byte_v;
                state_next.bit_cnt = state_reg.bit_cnt + 1'b1;
                // any further bit spoils a sequence that had just completed
                state_next.complete = 1'b0;
                if (byte_end) begin
                    case (state_reg.seq)
                        SEQ_CMD: begin
                            cmd_v = decode_cmd(byte_v);
                            if (state_reg.busy &&
                                cmd_v != CMD_STATUS_READ) begin
                                cmd_v = CMD_NONE;
                            end
                            state_next.cmd = cmd_v;
                            state_next.seq = SEQ_SKIP;
                            case (cmd_v)
                                CMD_LATCH_SET, CMD_LATCH_CLEAR: begin
                                    state_next.complete = 1'b1;
                                end
                                CMD_STATUS_READ: begin
                                    state_next.seq = SEQ_XFER;
                                    state_next.out_idx = OUT_FIRST_BIT;
                                end
                                CMD_STATUS_WRITE: begin
                                    if (state_reg.write_enable_latch) begin
                                        state_next.seq = SEQ_XFER;
                                    end
                                end
                                CMD_ARRAY_READ: begin
                                    state_next.seq = SEQ_ADDR;
                                end
                                CMD_ARRAY_WRITE: begin
                                    if (state_reg.write_enable_latch) begin
                                        state_next.seq = SEQ_ADDR;
                                        state_next.page_mask = '0;
                                    end
                                end
                                default: begin
                                end
                            endcase
                        end
                        SEQ_ADDR: begin
                            if (!state_reg.addr_hi) begin
                                state_next.addr_hi = 1'b1;
                                // top address bit is dropped
                                state_next.addr[ADDR_W-1:BYTE_W] =
                                    byte_v[ADDR_W-BYTE_W-1:0];
                            end else begin
                                state_next.addr[BYTE_W-1:0] = byte_v;
                                state_next.seq = SEQ_XFER;
                                state_next.out_idx = OUT_FIRST_BIT;
                            end
                        end
                        SEQ_XFER: begin
                            if (state_reg.cmd == CMD_ARRAY_WRITE) begin
                                col = state_reg.addr[PAGE_W-1:0];
                                if (!is_protected(state_reg.bp,
                                                  state_reg.addr)) begin
                                    state_next.page_data[col] = byte_v;
                                    state_next.page_mask[col] = 1'b1;
                                end
                                // column wraps inside the row
                                state_next.addr[PAGE_W-1:0] = col + 1'b1;
                                state_next.complete = 1'b1;
                            end else if (state_reg.cmd ==
                                         CMD_STATUS_WRITE) begin
                                state_next.wrsr_data = byte_v;
                                state_next.complete = 1'b1;
                                state_next.seq = SEQ_SKIP;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            // read phases: serial input is ignored, output moves on sck fall
            if (sck_fall && state_reg.seq == SEQ_XFER && reading) begin
                state_next.so_oe = 1'b1;
                if (state_reg.cmd == CMD_STATUS_READ) begin
                    state_next.so = stat_v[state_reg.out_idx];
                end else begin
                    state_next.so = mem_if.rd_data[state_reg.out_idx];
                    if (state_reg.out_idx == OUT_LAST_BIT) begin
                        state_next.addr = state_reg.addr + 1'b1;
                    end
                end
                state_next.out_idx = state_reg.out_idx - 1'b1;
            end
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= reset_state();
        end else begin
            state_reg <= state_next;
        end
    end

    // page commit: one buffered column per cycle at the start of the cycle
    assign mem_if.wr_en = state_reg.busy && !state_reg.wc_status &&
        !state_reg.commit_idx[PAGE_W] &&
        state_reg.page_mask[state_reg.commit_idx[PAGE_W-1:0]];
    assign mem_if.wr_addr = {state_reg.addr[ADDR_W-1:PAGE_W],
                             state_reg.commit_idx[PAGE_W-1:0]};
    assign mem_if.wr_data =
        state_reg.page_data[state_reg.commit_idx[PAGE_W-1:0]];
    assign mem_if.rd_addr = state_reg.addr;

    assign spi_so_out = state_reg.so;
    assign spi_so_oe_out = state_reg.so_oe;

endmodule : eep_spi_protect

// [verification/eep_spi_protect_chk.sv]
// port-level assertions for the eeprom spi slave
module eep_spi_protect_chk #(
    parameter int unsigned WC_CYCLES = 600
) (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_sck_in,
    input wire logic spi_si_in,
    input wire logic wp_n_in,
    input wire logic spi_so_out,
    input wire logic spi_so_oe_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    a_oe_drop_cs: assert property (
        $rose(spi_cs_n_in) |-> ##[1:6] !spi_so_oe_out)
        else $error("enable held after chip select rise");
    a_oe_idle_cs: assert property (
        spi_cs_n_in [*6] |-> !spi_so_oe_out)
        else $error("enable high while deselected");
    a_so_sck_low: assert property (
        $changed(spi_so_out) && spi_so_oe_out |-> !spi_sck_in)
        else $error("serial output moved while sck high");
    a_oe_in_frame: assert property (
        spi_so_oe_out |-> !$past(spi_cs_n_in, 6))
        else $error("enable high without a frame");
    a_oe_rise_ok: assert property (
        $rose(spi_so_oe_out) |-> !spi_cs_n_in && !spi_sck_in)
        else $error("enable rose outside a low sck phase");
    a_oe_fall_cs: assert property (
        $fell(spi_so_oe_out) |-> $past(spi_cs_n_in, 2) ||
            $past(spi_cs_n_in, 3) || $past(spi_cs_n_in, 4) ||
            $past(spi_cs_n_in, 5))
        else $error("enable dropped without chip select rise");
    a_oe_keeps: assert property (
        (!spi_cs_n_in [*6]) ##0 spi_so_oe_out |=> spi_so_oe_out)
        else $error("enable dropped inside a frame");
    a_so_one_bit: assert property (
        $changed(spi_so_out) && spi_so_oe_out && !spi_cs_n_in |=>
            ($stable(spi_so_out) || spi_cs_n_in) [*6])
        else $error("serial output moved twice in one sck period");
    c_read: cover property ($rose(spi_so_oe_out));
    c_frame: cover property ($rose(spi_cs_n_in));
    c_wp: cover property ($fell(wp_n_in));
endmodule : eep_spi_protect_chk

// [verification/eep_spi_master_model.sv]
// spi mode 0 bus master model that sends whole byte frames
module eep_spi_master_model (
    input wire logic clock_in,
    input wire logic so_in,
    output logic cs_n_out,
    output logic sck_out,
    output logic si_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cs_n_out = 1'b1;
        sck_out = 1'b0;
        si_out = 1'b0;
    end
    task automatic half();
        repeat (6) @(negedge clock_in);
    endtask : half
    // msb first, si moves only while sck is low
    task automatic frame(input logic [7:0] q[$], output logic [7:0] rq[$]);
        logic [7:0] b;
        rq = {};
        cs_n_out = 1'b0;
        foreach (q[k]) begin
            for (int i = 7; i >= 0; i--) begin
                si_out = q[k][i];
                half();
                sck_out = 1'b1;
                b[i] = so_in;
                half();
                sck_out = 1'b0;
            end
            rq.push_back(b);
        end
        half();
        // rise half an sck period after the last bit, sck low
        cs_n_out = 1'b1;
        si_out = ~si_out;
        half();
    endtask : frame
endmodule : eep_spi_master_model

// [verification/testbench.sv]
// self-checking bench for the eeprom command and protect logic
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import eep_pkg::*;
    localparam int WC = 600;
    logic clock_in = 1'b0;
    logic rstn_in = 1'b0;
    logic wp_n = 1'b1;
    logic cs_n, sck, si, so, so_oe;
    int fail_count = 0;
    int num_checks = 0;
    logic [7:0] r[$];
    always #2 clock_in = ~clock_in;
    eep_spi_protect #(.WC_CYCLES(WC)) eep_spi_protect_inst (
        .clock_in(clock_in),
        .rstn_in(rstn_in),
        .spi_cs_n_in(cs_n),
        .spi_sck_in(sck),
        .spi_si_in(si),
        .wp_n_in(wp_n),
        .spi_so_out(so),
        .spi_so_oe_out(so_oe)
    );
    eep_spi_master_model eep_spi_master_model_inst (
        .clock_in(clock_in),
        .so_in(so),
        .cs_n_out(cs_n),
        .sck_out(sck),
        .si_out(si)
    );
    task automatic end_of_test();
        if (fail_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic send(input logic [7:0] q[$]);
        eep_spi_master_model_inst.frame(q, r);
    endtask : send
    task automatic stat(input logic [7:0] exp);
        send('{OPC_STATUS_READ, 8'h00});
        chk(r[1], exp);
    endtask : stat
    // first read lands inside the write cycle, then polls until ready
    task automatic poll(input logic [7:0] busy_v, input logic [7:0] done_v);
        stat(busy_v);
        for (int i = 0; i < 20 && r[1][0] !== 1'b0; i++) begin
            send('{OPC_STATUS_READ, 8'h00});
        end
        if (r[1][0] !== 1'b0) begin
            fail_count++;
            end_of_test();
        end
        chk(r[1], done_v);
    endtask : poll
    task automatic sc_latch();
        stat(8'h00);
        send('{OPC_STATUS_WRITE, 8'h8c});
        stat(8'h00);
        send('{OPC_LATCH_SET});
        stat(8'h02);
        send('{OPC_LATCH_CLEAR});
        stat(8'h00);
    endtask : sc_latch
    task automatic sc_page();
        send('{OPC_LATCH_SET});
        send('{OPC_ARRAY_WRITE, 8'h7f, 8'hfe, 8'h11, 8'h22, 8'h33});
        send('{OPC_STATUS_WRITE, 8'h8c});
        poll(8'h73, 8'h00);
        send('{OPC_LATCH_SET});
        send('{OPC_ARRAY_WRITE, 8'h80, 8'h00, 8'h44});
        poll(8'h73, 8'h00);
        send('{OPC_ARRAY_READ, 8'hff, 8'hfe, 8'h00, 8'h00, 8'h00});
        chk(r[3], 8'h11);
        chk(r[4], 8'h22);
        chk(r[5], 8'h44);
        send('{OPC_ARRAY_READ, 8'h7f, 8'hc0, 8'h00});
        chk(r[3], 8'h33);
    endtask : sc_page
    task automatic sc_protect();
        send('{OPC_LATCH_SET});
        send('{OPC_STATUS_WRITE, 8'h84});
        poll(8'h73, 8'h84);
        wp_n = 1'b0;
        send('{OPC_LATCH_SET});
        send('{OPC_STATUS_WRITE, 8'h00});
        stat(8'h86);
        send('{OPC_ARRAY_WRITE, 8'h7f, 8'hff, 8'h55});
        poll(8'hf7, 8'h84);
        send('{OPC_LATCH_SET});
        send('{OPC_ARRAY_WRITE, 8'h00, 8'h00, 8'h66});
        poll(8'hf7, 8'h84);
        send('{OPC_ARRAY_READ, 8'h7f, 8'hff, 8'h00, 8'h00});
        chk(r[3], 8'h22);
        chk(r[4], 8'h66);
    endtask : sc_protect
    task automatic sc_release();
        wp_n = 1'b1;
        send('{OPC_LATCH_SET});
        send('{OPC_STATUS_WRITE, 8'h00, 8'hff});
        stat(8'h86);
        send('{OPC_STATUS_WRITE, 8'h0c});
        poll(8'hf7, 8'h0c);
        send('{OPC_LATCH_SET});
        send('{OPC_ARRAY_WRITE, 8'h00, 8'h00, 8'h77});
        poll(8'h7f, 8'h0c);
        send('{OPC_ARRAY_READ, 8'h00, 8'h00, 8'h00});
        chk(r[3], 8'h66);
        send('{OPC_LATCH_SET});
        send('{OPC_STATUS_WRITE, 8'h08});
        poll(8'h7f, 8'h08);
        send('{OPC_LATCH_SET});
        send('{OPC_ARRAY_WRITE, 8'h7f, 8'hc0, 8'h99});
        poll(8'h7b, 8'h08);
        send('{OPC_LATCH_SET});
        send('{OPC_ARRAY_WRITE, 8'h3f, 8'hff, 8'h88});
        poll(8'h7b, 8'h08);
        send('{OPC_ARRAY_READ, 8'h3f, 8'hff, 8'h00});
        chk(r[3], 8'h88);
        send('{OPC_ARRAY_READ, 8'h7f, 8'hc0, 8'h00});
        chk(r[3], 8'h33);
    endtask : sc_release
    initial begin
        repeat (10) @(negedge clock_in);
        rstn_in = 1'b1;
        repeat (6) @(negedge clock_in);
        sc_latch();
        sc_page();
        sc_protect();
        sc_release();
        end_of_test();
    end
    initial begin
        repeat (100000) @(posedge clock_in);
        fail_count++;
        end_of_test();
    end
endmodule : testbench
bind eep_spi_protect eep_spi_protect_chk #(.WC_CYCLES(WC_CYCLES))
    eep_spi_protect_chk_inst (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .spi_cs_n_in(spi_cs_n_in),
    .spi_sck_in(spi_sck_in),
    .spi_si_in(spi_si_in),
    .wp_n_in(wp_n_in),
    .spi_so_out(spi_so_out),
    .spi_so_oe_out(spi_so_oe_out)
);
